/* dv/dsar_master.sv */
// Purpose: serial master model, one frame per go pulse
// Assumes: 320 ns serial clock idling low
// Notes: n_i clocks per frame; under 15 aborts
`timescale 1ns/1ns
module dsar_master (
    input logic go_i,
    input logic [4:0] n_i,
    input logic sdout_i,
    output logic sclk_o,
    output logic sel_n_o,
    output logic [12:0] word_o,
    output logic done_o
);
    // ====================
    // frame: select, 1.5 acquire clocks, 13 result clocks
    initial begin
        {sclk_o, sel_n_o, word_o, done_o} = 16'h4000;
    end
    always @(posedge go_i) begin
        {done_o, sel_n_o, word_o} = '0;
        #407;
        for (int i = 1; i <= n_i; i++) begin // slow clock
            sclk_o = 1'b1;
            if (i > 2) word_o = {word_o[11:0], sdout_i};
            #160 sclk_o = 1'b0;
            #160;
        end
        {sel_n_o, done_o} = 2'b11;
    end
endmodule // dsar_master

/* dv/dsar_readout_assertions.sv */
// Purpose: pin timing checks on the readout
// Assumes: serial clock phases last 4 core clocks
// Notes: bound into every readout
`timescale 1ns/1ns
module dsar_readout_chk (
    input logic core_clk_i,
    input logic srst_i,
    input logic sclk_i,
    input logic select_and_standby_n_i,
    input logic sdout_o,
    input logic sdout_oe_o,
    input logic hold_capacitor_track_o,
    input logic standby_o,
    input logic busy_o
);
    // ====================
    // four samples cover the two-flop pin sync
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    AST_OE_SEL: assert property (!select_and_standby_n_i [*4] |-> sdout_oe_o)
        else $error("output off while selected");
    AST_STANDBY: assert property (select_and_standby_n_i [*4] |-> standby_o && !busy_o)
        else $error("busy after deselect");
    AST_RELEASE: assert property (select_and_standby_n_i [*4] |-> !sdout_oe_o)
        else $error("driven while deselected");
    AST_EDGE: assert property ($changed(sdout_o) |-> !sclk_i || select_and_standby_n_i)
        else $error("output moved with clock high");
    AST_TRACK: assert property (hold_capacitor_track_o |-> busy_o)
        else $error("acquiring while idle");
    AST_HOLD: assert property ($fell(hold_capacitor_track_o) |-> sclk_i)
        else $error("hold opened off a rising clock");
    AST_NEXT: assert property ($fell(hold_capacitor_track_o) && !select_and_standby_n_i
        |-> busy_o) else $error("conversion did not follow");
    AST_END: assert property ($rose(busy_o) |-> ##[1:200] !busy_o)
        else $error("conversion never ended");
endmodule // dsar_readout_chk
bind dsar_readout dsar_readout_chk u_chk (.*);

/* dv/dsar_readout_tb.sv */
// Purpose: self-checking bench for the readout
// Assumes: master model collects each frame
// Notes: sample codes stand in for the input difference
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module dsar_readout_tb;
    logic clk = 1'b0, srst = 1'b1, unip = 1'b0, go = 1'b0;
    logic sclk, sel_n, done, sdout, oe, track, standby, busy, line;
    logic [12:0] sample = 13'h0000, word;
    logic [4:0] n = 5'h0F;
    int err_total = 0, comparisons = 0;
    // ====================
    // released line toggles so a stale bit never passes
    assign line = oe ? sdout : clk;
    dsar_readout dut (.core_clk_i(clk), .srst_i(srst), .sclk_i(sclk),
        .select_and_standby_n_i(sel_n), .sample_i(sample), .unipolar_i(unip), .sdout_o(sdout),
        .sdout_oe_o(oe), .hold_capacitor_track_o(track), .standby_o(standby), .busy_o(busy));
    dsar_master u_mst (.go_i(go), .n_i(n), .sdout_i(line), .sclk_o(sclk), .sel_n_o(sel_n),
        .word_o(word), .done_o(done));
    initial begin
        forever #20 clk = ~clk;
    end
    task frame(input logic [12:0] s, input logic u, input logic [4:0] k);
        @(negedge clk);
        {sample, unip, n, go} = {s, u, k, 1'b1};
        @(negedge clk) go = 1'b0;
        for (int i = 0; i < 300 && !done; i++) @(negedge clk);
        `CHK("done", 1'b1, done)
        repeat (4) @(negedge clk);
    endtask
    task t_codes; // boundary and zero codes
        logic [12:0] c [5] = '{13'h0FFF, 13'h1000, 13'h0001, 13'h0000, 13'h1ABC};
        foreach (c[i]) begin
            frame(c[i], 1'b0, 5'h0F);
            `CHK("word", c[i], word)
            `CHK("oe", 1'b0, oe)
        end
    endtask
    task t_unip; // negatives clamp, positives pass
        frame(13'h1800, 1'b1, 5'h0F);
        `CHK("uneg", 13'h0000, word)
        frame(13'h0ABC, 1'b1, 5'h0F);
        `CHK("upos", 13'h0ABC, word)
    endtask
    task t_abort; // deselect after four result clocks
        frame(13'h0FFF, 1'b0, 5'h06);
        `CHK("busy", 1'b0, busy)
        `CHK("standby", 1'b1, standby)
        frame(13'h1555, 1'b0, 5'h0F);
        `CHK("next", 13'h1555, word)
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin // traffic needs about 46 us
        #200000;
        err_total++;
        complete_run;
    end
    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        t_codes;
        t_unip;
        t_abort;
        complete_run;
    end
endmodule // dsar_readout_tb

/* rtl/dsar_edge_sync.sv */
// Purpose: two-flop synchronisers and edge finding for the serial pins
// Assumes: pins are asynchronous to core_clk_i
// Notes: first flop of each chain feeds only the second
`timescale 1ns/1ns
module dsar_edge_sync
    import dsar_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic select_and_standby_n_i,
    output dsar_link_type link_o
);
    logic [1:0] clk_meta_r;
    logic [1:0] sel_meta_r;
    logic clk_last_r;

    // ==========================================================
    // synchronise; select idles high so reset parks it there
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            clk_meta_r <= 2'h0;
            sel_meta_r <= 2'h3;
            clk_last_r <= 1'b0;
        end else begin
            clk_meta_r <= {clk_meta_r[0], sclk_i};
            sel_meta_r <= {sel_meta_r[0], select_and_standby_n_i};
            clk_last_r <= clk_meta_r[1];
        end
    end

    // edges seen from the second stage only
    assign link_o.sel_n = sel_meta_r[1];
    assign link_o.rise = clk_meta_r[1] & ~clk_last_r;
    assign link_o.fall = ~clk_meta_r[1] & clk_last_r;
endmodule // dsar_edge_sync

/* rtl/dsar_pkg.sv */
// Purpose: shared constants and types for the differential converter serial readout
// Assumes: core clock 25 MHz; serial clock and select arrive unsynchronised
// Notes: the converted sample comes in as a 13-bit two's-complement word
package dsar_pkg;

    // ==========================================================
    // widths and counts
    localparam int DSAR_RES_W = 13;
    localparam logic [3:0] DSAR_BITS = 4'hD;
    localparam logic [12:0] DSAR_MAX_POS = 13'h0FFF;
    localparam logic [12:0] DSAR_MAX_NEG = 13'h1000;
    localparam logic [3:0] DSAR_SIGN_POS = 4'hC;

    // ==========================================================
    // readout phases
    typedef enum logic [1:0] {
        DSAR_IDLE,
        DSAR_ACQ,
        DSAR_CONV,
        DSAR_DONE
    } dsar_state_type;

    // synchronised select level and serial clock edges
    typedef struct packed {
        logic sel_n;
        logic rise;
        logic fall;
    } dsar_link_type;

endpackage

/* rtl/dsar_readout.sv */
// Purpose: serial sequencing and result shift-out of the differential converter
// Assumes: sample_i holds the converter's signed difference code
// Notes: the analog side is abstracted as a word captured when the hold opens
`timescale 1ns/1ns
module dsar_readout
    import dsar_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic select_and_standby_n_i,
    input wire logic [12:0] sample_i,
    input wire logic unipolar_i,
    output logic sdout_o,
    output logic sdout_oe_o,
    output logic hold_capacitor_track_o,
    output logic standby_o,
    output logic busy_o
);
    dsar_link_type link;
    dsar_state_type state_r;
    logic [1:0] half_r;
    logic [3:0] bit_cnt_r;
    logic [12:0] shift_r;
    logic dout_r;

    // bipolar codes pass unchanged; unipolar clamps negatives to zero
    function automatic logic [12:0] dsar_code(input logic [12:0] s, input logic uni);
        logic [12:0] c;
        c = s; // in bipolar mode every code from 0x1000 up to 0x0FFF passes unchanged
        if (uni && s[DSAR_SIGN_POS]) begin
            c = 13'h0000;
        end
        return c;
    endfunction

    dsar_edge_sync u_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .sclk_i(sclk_i),
        .select_and_standby_n_i(select_and_standby_n_i),
        .link_o(link)
    );

    // ==========================================================
    // phase sequencing; select high always wins
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_r <= DSAR_IDLE;
            half_r <= 2'h0;
            bit_cnt_r <= 4'h0;
        end else if (link.sel_n) begin
            state_r <= DSAR_IDLE;
            half_r <= 2'h0;
            bit_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                DSAR_IDLE: begin
                    state_r <= DSAR_ACQ;
                    half_r <= 2'h0;
                end
                DSAR_ACQ: begin
                    // 1.5 clocks: rise, fall, rise counted as three half periods
                    if (link.rise || (link.fall && half_r != 2'h0)) begin
                        half_r <= half_r + 2'h1;
                        if (half_r == 2'h2) begin
                            state_r <= DSAR_CONV;
                            bit_cnt_r <= 4'h0;
                        end
                    end
                end
                DSAR_CONV: begin
                    if (link.fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == DSAR_BITS - 4'h1) begin
                            state_r <= DSAR_DONE;
                        end
                    end
                end
                DSAR_DONE: state_r <= DSAR_DONE; // wait for select high
                default: state_r <= DSAR_IDLE;
            endcase
        end
    end

    // ==========================================================
    // capture when the hold switch opens, shift on falling edges
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            shift_r <= 13'h0000;
            dout_r <= 1'b0;
        end else if (link.sel_n) begin
            dout_r <= 1'b0;
        end else if (state_r == DSAR_ACQ && link.rise && half_r == 2'h2) begin
            shift_r <= dsar_code(sample_i, unipolar_i);
        end else if (state_r == DSAR_CONV && link.fall) begin
            // sign leaves first, then the two's-complement bits 11 down to the lsb
            dout_r <= shift_r[DSAR_SIGN_POS];
            shift_r <= {shift_r[11:0], 1'b0};
        end
    end

    // ==========================================================
    // pins and status; output released whenever deselected
    assign sdout_o = dout_r;
    assign sdout_oe_o = ~link.sel_n;
    assign hold_capacitor_track_o = (state_r == DSAR_ACQ);
    assign standby_o = link.sel_n;
    assign busy_o = (state_r == DSAR_ACQ) || (state_r == DSAR_CONV);
endmodule // dsar_readout
